// >>> pkg/frp_pkg.sv
// constants and types for fault response and power state control
package frp_pkg;
  localparam int CLK_MHZ          = 100;
  // timing, in microseconds, and the same in clock cycles
  localparam int RETRY_US         = 4000;
  localparam int SLEEP_US         = 1000;
  localparam int WAKE_US          = 1000;
  localparam int CLEAR_WIN_US     = 5;
  localparam int RETRY_CYC        = RETRY_US * CLK_MHZ;
  localparam int SLEEP_CYC        = SLEEP_US * CLK_MHZ;
  localparam int WAKE_CYC         = WAKE_US * CLK_MHZ;
  localparam int CLEAR_WIN_CYC    = CLEAR_WIN_US * CLK_MHZ;
  localparam int CNT_W            = 20;
  // apb register map
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [1:0]  SEL_NONE    = 2'h0;
  localparam logic [1:0]  SEL_CTRL    = 2'h1;
  localparam logic [1:0]  SEL_STATUS  = 2'h2;
  // control fields
  localparam int CTRL_WARN_PIN    = 0;
  localparam int CTRL_POLICY_LO   = 1;
  localparam int CTRL_SHUNT_OFF   = 3;
  localparam int CTRL_STUCK_OFF   = 4;
  localparam int CTRL_UV_OFF      = 5;
  localparam int CTRL_CLEAR       = 6;
  localparam logic [1:0] POL_LATCH  = 2'h0;
  localparam logic [1:0] POL_RETRY  = 2'h1;
  localparam logic [1:0] POL_REPORT = 2'h2;
  localparam logic [1:0] POL_OFF    = 2'h3;
  localparam logic [1:0] POLICY_RST = 2'h0;
  // status fields
  localparam int ST_ANY     = 0;
  localparam int ST_WARN    = 1;
  localparam int ST_TRIP    = 2;
  localparam int ST_MAIN    = 3;
  localparam int ST_DRAIN   = 4;
  localparam int ST_PUMP    = 5;
  localparam int ST_LOWSIDE = 6;
  localparam int ST_DSOC    = 7;
  localparam int ST_SHUNT   = 8;
  localparam int ST_STUCK   = 9;
  localparam int ST_RETRY   = 10;
  localparam int ST_READY   = 11;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_WAKE, MODE_RUN} frp_mode_e;

  typedef struct packed {
    logic tempWarn;
    logic tempTrip;
    logic mainSupplyLow;
    logic drainSenseSupplyLow;
    logic pumpSupplyLow;
    logic lowsideSupplyLow;
    logic drainSourceOvercurrent;
    logic shuntOvercurrent;
    logic gateStuckFault;
  } frp_fault_in_s;

  typedef struct packed {
    logic active;
    logic hiZ;
    logic pulledOff;
  } frp_gate_s;

  typedef struct packed {
    logic       warnToPinEn;
    logic [1:0] overcurrentPolicy;
    logic       shuntTripDisable;
    logic       gateStuckCheckOff;
    logic       gateSupplyUvCheckOff;
  } frp_cfg_s;
endpackage

// >>> design/frp_fault_power.sv
// fault supervision and power state control with apb register access
// Overview of operation
// - temperature warning sets overtemp_warn_flag only; gates keep driving
// - overtemp_warn_flag follows the warning level, clearing itself
// - warn_to_pin_en routes the warning onto alarm pin and any flag
// - shutdown temperature: gates off, pump off, alarm, latch trip flags
// - gates and pin recover when cool; trip flag waits for a clear
// - thermal shutdown has no disable setting
// - main supply low alarms and releases gates, recovers by itself
// - drain sense supply low alarms and releases gates, recovers by itself
// - pump or lowside supply low act unless gate_supply_uv_check_off set
// - drain overcurrent follows policy: latch, retry, report only
// - shunt overcurrent follows the same policy codes
// - policy 11b ignores both overcurrent events; shunt_trip_disable ignores the shunt one
// - gate stuck fault latches gates released unless check turned off
// - enable low past sleep delay: sleep, everything off, registers reset
// - enable high wakes the device; controller waits out wake delay
// - sleep or main supply lockout holds gates pulled off
// - operating mode only with enable high and main supply good
// - latched overcurrent and gate stuck faults hold shutdown until condition gone and cleared
// - short enable low pulse clears; longer low begins shutdown
// - enable reset pulse clears faults only, settings untouched
// - retry flags stay set until retry delay ends, then clear
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module frp_fault_power #(
  parameter int RETRY_CYCLES = frp_pkg::RETRY_CYC,
  parameter int SLEEP_CYCLES = frp_pkg::SLEEP_CYC,
  parameter int WAKE_CYCLES  = frp_pkg::WAKE_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic                  enable,
  input  wire frp_pkg::frp_fault_in_s faultIn,
  output logic                       alarmPinLow,
  output logic                       anyAlarmFlag,
  output frp_pkg::frp_gate_s         gateOut,
  output logic                       chargePumpOn,
  output logic                       regulatorsOn,
  output logic                       readyForInputs
);

  typedef struct packed {
    frp_pkg::frp_mode_e        mode;
    frp_pkg::frp_cfg_s         cfg;
    logic                      warnFlag;
    logic                      tripFlag;
    logic                      dsFlag;
    logic                      shuntFlag;
    logic                      stuckFlag;
    logic                      retryBusy;
    logic [frp_pkg::CNT_W-1:0] retryCnt;
    logic [frp_pkg::CNT_W-1:0] lowCnt;
    logic [frp_pkg::CNT_W-1:0] wakeCnt;
    logic                      enPrev;
    logic                      pready;
    logic [31:0]               prdata;
    logic                      pslverr;
    logic                      alarmLow;
    logic                      anyAlarm;
    frp_pkg::frp_gate_s        gate;
    logic                      pumpOn;
    logic                      regsOn;
    logic                      ready;
  } frp_state_s;

  localparam frp_pkg::frp_cfg_s CFG_RST = '{
    warnToPinEn:          1'b0,
    overcurrentPolicy:    frp_pkg::POLICY_RST,
    shuntTripDisable:     1'b0,
    gateStuckCheckOff:    1'b0,
    gateSupplyUvCheckOff: 1'b0
  };

  localparam logic [frp_pkg::CNT_W-1:0] RETRY_LAST =
    frp_pkg::CNT_W'(RETRY_CYCLES - 1);
  localparam logic [frp_pkg::CNT_W-1:0] SLEEP_LAST =
    frp_pkg::CNT_W'(SLEEP_CYCLES - 1);
  localparam logic [frp_pkg::CNT_W-1:0] WAKE_LAST =
    frp_pkg::CNT_W'(WAKE_CYCLES - 1);
  localparam logic [frp_pkg::CNT_W-1:0] CLEAR_WIN =
    frp_pkg::CNT_W'(frp_pkg::CLEAR_WIN_CYC);
  localparam logic [frp_pkg::CNT_W-1:0] CNT_MAX = '1;

  function automatic logic [1:0] regSel(input logic [11:0] addr);
    if (addr == frp_pkg::ADDR_CTRL) begin
      regSel = frp_pkg::SEL_CTRL;
    end else if (addr == frp_pkg::ADDR_STATUS) begin
      regSel = frp_pkg::SEL_STATUS;
    end else begin
      regSel = frp_pkg::SEL_NONE;
    end
  endfunction

  frp_state_s s_r;
  frp_state_s s_nxt;

  always_comb begin
    logic       clearCmd;
    logic       clearPulse;
    logic       clearAll;
    logic       shuttingDown;
    logic       dsEvent;
    logic       shuntEvent;
    logic       stuckEvent;
    logic       retryDone;
    logic       uvHit;
    logic       ocHold;
    logic       gatesOff;
    logic       report;
    logic       lockout;
    logic [31:0] ctrlWord;
    logic [31:0] statWord;
    clearCmd     = 1'b0;
    clearPulse   = 1'b0;
    clearAll     = 1'b0;
    shuttingDown = 1'b0;
    dsEvent      = 1'b0;
    shuntEvent   = 1'b0;
    stuckEvent   = 1'b0;
    retryDone    = 1'b0;
    uvHit        = 1'b0;
    ocHold       = 1'b0;
    gatesOff     = 1'b0;
    report       = 1'b0;
    lockout      = 1'b0;
    ctrlWord     = 32'h0000_0000;
    statWord     = 32'h0000_0000;
    s_nxt        = s_r;

    ctrlWord[frp_pkg::CTRL_WARN_PIN] = s_r.cfg.warnToPinEn;
    ctrlWord[frp_pkg::CTRL_POLICY_LO +: 2] = s_r.cfg.overcurrentPolicy;
    ctrlWord[frp_pkg::CTRL_SHUNT_OFF] = s_r.cfg.shuntTripDisable;
    ctrlWord[frp_pkg::CTRL_STUCK_OFF] = s_r.cfg.gateStuckCheckOff;
    ctrlWord[frp_pkg::CTRL_UV_OFF] = s_r.cfg.gateSupplyUvCheckOff;
    statWord[frp_pkg::ST_ANY] = s_r.anyAlarm;
    statWord[frp_pkg::ST_WARN] = s_r.warnFlag;
    statWord[frp_pkg::ST_TRIP] = s_r.tripFlag;
    statWord[frp_pkg::ST_MAIN] = faultIn.mainSupplyLow;
    statWord[frp_pkg::ST_DRAIN] = faultIn.drainSenseSupplyLow;
    statWord[frp_pkg::ST_PUMP] = faultIn.pumpSupplyLow;
    statWord[frp_pkg::ST_LOWSIDE] = faultIn.lowsideSupplyLow;
    statWord[frp_pkg::ST_DSOC] = s_r.dsFlag;
    statWord[frp_pkg::ST_SHUNT] = s_r.shuntFlag;
    statWord[frp_pkg::ST_STUCK] = s_r.stuckFlag;
    statWord[frp_pkg::ST_RETRY] = s_r.retryBusy;
    statWord[frp_pkg::ST_READY] = s_r.ready;

    // apb: one wait state, answer registered
    s_nxt.pready = 1'b0;
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata  = 32'h0000_0000;
      if (regSel(paddr) == frp_pkg::SEL_CTRL) begin
        s_nxt.prdata = ctrlWord;
      end else if (regSel(paddr) == frp_pkg::SEL_STATUS) begin
        s_nxt.prdata = statWord;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    // writes are dropped while asleep; reads are still answered then
    if (psel && penable && s_r.pready && pwrite && s_r.mode != MODE_SLEEP_C()) begin
      if (regSel(paddr) == frp_pkg::SEL_CTRL) begin
        s_nxt.cfg.warnToPinEn = pwdata[frp_pkg::CTRL_WARN_PIN];
        s_nxt.cfg.overcurrentPolicy = pwdata[frp_pkg::CTRL_POLICY_LO +: 2];
        s_nxt.cfg.shuntTripDisable = pwdata[frp_pkg::CTRL_SHUNT_OFF];
        s_nxt.cfg.gateStuckCheckOff = pwdata[frp_pkg::CTRL_STUCK_OFF];
        s_nxt.cfg.gateSupplyUvCheckOff = pwdata[frp_pkg::CTRL_UV_OFF];
        clearCmd = pwdata[frp_pkg::CTRL_CLEAR];
      end
    end

    // enable pulse timing
    s_nxt.enPrev = enable;
    if (!enable) begin
      if (s_r.lowCnt != CNT_MAX) begin
        s_nxt.lowCnt = s_r.lowCnt + 1'b1;
      end
      shuttingDown = (s_r.lowCnt >= CLEAR_WIN);
    end else begin
      s_nxt.lowCnt = '0;
      if (!s_r.enPrev && s_r.lowCnt < CLEAR_WIN && s_r.mode != MODE_SLEEP_C()) begin
        clearPulse = 1'b1;
      end
    end
    clearAll = clearCmd | clearPulse;

    // power modes
    case (s_r.mode)
      frp_pkg::MODE_SLEEP: begin
        if (enable) begin
          s_nxt.mode    = frp_pkg::MODE_WAKE;
          s_nxt.wakeCnt = '0;
        end
      end
      frp_pkg::MODE_WAKE: begin
        if (!enable && s_r.lowCnt >= SLEEP_LAST) begin
          s_nxt.mode = frp_pkg::MODE_SLEEP;
        end else if (s_r.wakeCnt == WAKE_LAST) begin
          s_nxt.mode = frp_pkg::MODE_RUN;
        end else begin
          s_nxt.wakeCnt = s_r.wakeCnt + 1'b1;
        end
      end
      default: begin
        if (!enable && s_r.lowCnt >= SLEEP_LAST) begin
          s_nxt.mode = frp_pkg::MODE_SLEEP;
        end
      end
    endcase

    // fault detection and policy
    s_nxt.warnFlag = faultIn.tempWarn;
    if (faultIn.tempTrip) begin
      s_nxt.tripFlag = 1'b1;
    end else if (clearAll) begin
      s_nxt.tripFlag = 1'b0;
    end
    dsEvent = faultIn.drainSourceOvercurrent &&
              s_r.cfg.overcurrentPolicy != frp_pkg::POL_OFF;
    shuntEvent = faultIn.shuntOvercurrent && !s_r.cfg.shuntTripDisable &&
                 s_r.cfg.overcurrentPolicy != frp_pkg::POL_OFF;
    stuckEvent = faultIn.gateStuckFault && !s_r.cfg.gateStuckCheckOff;

    if (s_r.retryBusy) begin
      s_nxt.retryCnt = s_r.retryCnt + 1'b1;
      retryDone = (s_r.retryCnt == RETRY_LAST);
    end
    if (retryDone || clearAll) begin
      s_nxt.dsFlag    = 1'b0;
      s_nxt.shuntFlag = 1'b0;
    end
    if (clearAll) begin
      s_nxt.stuckFlag = 1'b0;
    end
    // a new event wins over a clear or a retry end in the same cycle, but not over sleep
    if (dsEvent) begin
      s_nxt.dsFlag = 1'b1;
    end
    if (shuntEvent) begin
      s_nxt.shuntFlag = 1'b1;
    end
    if (stuckEvent) begin
      s_nxt.stuckFlag = 1'b1;
    end
    if ((dsEvent || shuntEvent) && s_r.cfg.overcurrentPolicy == frp_pkg::POL_RETRY) begin
      s_nxt.retryBusy = 1'b1;
      s_nxt.retryCnt  = '0;
    end else if (retryDone) begin
      s_nxt.retryBusy = 1'b0;
    end

    // sleep wipes settings and flags; a reset pulse never gets here
    if (s_nxt.mode == frp_pkg::MODE_SLEEP) begin
      s_nxt.cfg       = CFG_RST;
      s_nxt.warnFlag  = 1'b0;
      s_nxt.tripFlag  = 1'b0;
      s_nxt.dsFlag    = 1'b0;
      s_nxt.shuntFlag = 1'b0;
      s_nxt.stuckFlag = 1'b0;
      s_nxt.retryBusy = 1'b0;
      s_nxt.retryCnt  = '0;
    end

    // outputs, from the next state so flags and pins move together
    lockout = (s_nxt.mode == frp_pkg::MODE_SLEEP) || faultIn.mainSupplyLow;
    uvHit = faultIn.mainSupplyLow || faultIn.drainSenseSupplyLow ||
            (!s_nxt.cfg.gateSupplyUvCheckOff &&
             (faultIn.pumpSupplyLow || faultIn.lowsideSupplyLow));
    ocHold = s_nxt.retryBusy ||
             (s_nxt.cfg.overcurrentPolicy == frp_pkg::POL_LATCH &&
              (s_nxt.dsFlag || s_nxt.shuntFlag));
    gatesOff = uvHit || faultIn.tempTrip || ocHold || s_nxt.stuckFlag;
    report = uvHit || faultIn.tempTrip || s_nxt.dsFlag || s_nxt.shuntFlag ||
             s_nxt.stuckFlag ||
             (s_nxt.warnFlag && s_nxt.cfg.warnToPinEn);
    if (s_nxt.mode == frp_pkg::MODE_SLEEP) begin
      report = 1'b0;
    end
    s_nxt.alarmLow = !report;
    s_nxt.anyAlarm = report || s_nxt.tripFlag;
    s_nxt.gate.active = (s_nxt.mode == frp_pkg::MODE_RUN) && !lockout &&
                        !gatesOff && !shuttingDown;
    s_nxt.gate.hiZ = !s_nxt.gate.active;
    s_nxt.gate.pulledOff = lockout;
    s_nxt.regsOn = (s_nxt.mode != frp_pkg::MODE_SLEEP) &&
                   !faultIn.mainSupplyLow;
    s_nxt.pumpOn = s_nxt.regsOn && !faultIn.tempTrip;
    s_nxt.ready = (s_nxt.mode == frp_pkg::MODE_RUN) && s_nxt.regsOn;
  end

  function automatic frp_pkg::frp_mode_e MODE_SLEEP_C();
    MODE_SLEEP_C = frp_pkg::MODE_SLEEP;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r.mode      <= frp_pkg::MODE_SLEEP;
      s_r.cfg       <= CFG_RST;
      s_r.warnFlag  <= 1'b0;
      s_r.tripFlag  <= 1'b0;
      s_r.dsFlag    <= 1'b0;
      s_r.shuntFlag <= 1'b0;
      s_r.stuckFlag <= 1'b0;
      s_r.retryBusy <= 1'b0;
      s_r.retryCnt  <= '0;
      s_r.lowCnt    <= '0;
      s_r.wakeCnt   <= '0;
      s_r.enPrev    <= 1'b0;
      s_r.pready    <= 1'b0;
      s_r.prdata    <= 32'h0000_0000;
      s_r.pslverr   <= 1'b0;
      s_r.alarmLow  <= 1'b1;
      s_r.anyAlarm  <= 1'b0;
      s_r.gate      <= '{active: 1'b0, hiZ: 1'b1, pulledOff: 1'b1};
      s_r.pumpOn    <= 1'b0;
      s_r.regsOn    <= 1'b0;
      s_r.ready     <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready         = s_r.pready;
  assign prdata         = s_r.prdata;
  assign pslverr        = s_r.pslverr;
  assign alarmPinLow    = s_r.alarmLow;
  assign anyAlarmFlag   = s_r.anyAlarm;
  assign gateOut        = s_r.gate;
  assign chargePumpOn   = s_r.pumpOn;
  assign regulatorsOn   = s_r.regsOn;
  assign readyForInputs = s_r.ready;

endmodule
`default_nettype wire

// >>> test/frp_fault_power_assertions.sv
// concurrent checks on the fault and power state block ports
`timescale 1ns/1ps
`default_nettype none
module frp_fault_power_assertions #(
  parameter int SLEEP_CYCLES = 20
) (
  input wire logic                   sys_clk,
  input wire logic                   reset,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   enable,
  input wire frp_pkg::frp_fault_in_s faultIn,
  input wire logic                   alarmPinLow,
  input wire logic                   anyAlarmFlag,
  input wire frp_pkg::frp_gate_s     gateOut,
  input wire logic                   chargePumpOn,
  input wire logic                   regulatorsOn,
  input wire logic                   readyForInputs
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  int lowCnt_r;
  // saturating, so a long sleep cannot wrap it
  always_ff @(posedge sys_clk) begin
    if (reset || enable) lowCnt_r <= 0;
    else if (lowCnt_r < SLEEP_CYCLES + 8) lowCnt_r <= lowCnt_r + 1;
  end
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_one_wait: assert property (s_access |=> s_answer)
    else $error("apb answer not after one wait state");
  a_trip_drops_gates: assert property (regulatorsOn && faultIn.tempTrip |=>
    !gateOut.active && !chargePumpOn && !alarmPinLow && anyAlarmFlag)
    else $error("shutdown temperature not acted on");
  a_main_low_off: assert property (regulatorsOn && faultIn.mainSupplyLow |=>
    gateOut.hiZ && gateOut.pulledOff && !alarmPinLow)
    else $error("main supply low not acted on");
  a_alarm_has_flag: assert property (!anyAlarmFlag |-> alarmPinLow)
    else $error("alarm pin low without any flag");
  a_gates_need_run: assert property (gateOut.active |-> regulatorsOn && chargePumpOn)
    else $error("gates driven outside operating mode");
  a_ready_after_wake: assert property ($rose(readyForInputs) |-> enable && $past(enable, 10))
    else $error("ready without wake delay");
  a_run_needs_supply: assert property ($rose(regulatorsOn) |->
    $past(enable) && !$past(faultIn.mainSupplyLow))
    else $error("operating mode without enable or supply");
  a_long_low_off: assert property (lowCnt_r > 505 |-> !gateOut.active)
    else $error("gates active after long enable low");
  a_sleep_entry: assert property (lowCnt_r > SLEEP_CYCLES + 3 |->
    !regulatorsOn && gateOut.pulledOff)
    else $error("no sleep after enable low");
endmodule
`default_nettype wire

// >>> test/frp_controller_model.sv
// behavioural motor controller model driving the enable pin
`timescale 1ns/1ps
`default_nettype none
module frp_controller_model #(
  parameter int WAKE = 20
) (
  input  wire logic sys_clk,
  input  wire logic readyForInputs,
  output logic      enable
);
  initial enable = 1'b0;
  // no input until the wake delay has run out
  task automatic wake(output logic ok);
    @(posedge sys_clk);
    enable <= 1'b1;
    repeat (WAKE) @(posedge sys_clk);
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      @(posedge sys_clk);
      ok = readyForInputs;
    end
  endtask
  // high-low-high, low part kept inside the clear window
  task automatic pulse(input int n);
    @(posedge sys_clk);
    enable <= 1'b0;
    repeat (n) @(posedge sys_clk);
    enable <= 1'b1;
  endtask
  task automatic rest();
    @(posedge sys_clk);
    enable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/test_fault_response_power_state.sv
// self-checking bench for fault response and power state control
`timescale 1ns/1ps
`default_nettype none
module test_fault_response_power_state;
  localparam int RT = 20;
  logic                   sys_clk, reset, psel, penable, pwrite, pready, pslverr, er, ok, r, z;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd, cfg;
  logic                   enable, alarmPinLow, anyAlarmFlag, chargePumpOn;
  logic                   regulatorsOn, readyForInputs;
  frp_pkg::frp_fault_in_s faultIn;
  frp_pkg::frp_gate_s     gateOut;
  int                     bad_count, n_tests;
  frp_fault_power #(.RETRY_CYCLES(RT), .SLEEP_CYCLES(600), .WAKE_CYCLES(20)) dut (
    .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .enable, .faultIn, .alarmPinLow, .anyAlarmFlag, .gateOut, .chargePumpOn,
    .regulatorsOn, .readyForInputs);
  frp_controller_model #(.WAKE(20)) ctl (.sys_clk, .readyForInputs, .enable);
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] d);
    apb(1'b1, frp_pkg::ADDR_CTRL, d, rd, er);
    apb(1'b0, frp_pkg::ADDR_CTRL, '0, rd, er);
    check("ctrl", rd, d & 32'h3F);
  endtask
  task automatic up();
    ctl.wake(ok);
    check("ready", ok, 1'b1);
    if (ok !== 1'b1) conclude();
  endtask
  task automatic hit(input logic [8:0] f, input logic [1:0] dur, aft, input int w);
    @(posedge sys_clk);
    faultIn <= frp_pkg::frp_fault_in_s'(f);
    tick(3);
    check("during", {alarmPinLow, gateOut.active}, dur);
    faultIn <= '0;
    tick(w);
    check("after", {alarmPinLow, gateOut.active}, aft);
  endtask
  task automatic clr();
    wr(cfg | 32'h40);
    tick(2);
    check("cleared", {alarmPinLow, gateOut.active}, 2'b11);
  endtask
  // {reported, gates released} for an overcurrent
  function automatic logic [1:0] ocExp(input logic [1:0] pol, input logic off);
    logic rep;
    rep = pol != frp_pkg::POL_OFF && !off;
    return {rep, rep && pol < frp_pkg::POL_REPORT};
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    faultIn = '0;
    bad_count = 0;
    n_tests = 0;
    cfg = $urandom(32'hF172);
    tick(4);
    reset <= 1'b0;
    up();
    apb(1'b0, frp_pkg::ADDR_STATUS, '0, rd, er);
    check("status", rd, 32'h800);
    apb(1'b0, 12'h008, '0, rd, er);
    check("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 3; s++) begin
        cfg = ($urandom & 32'h31) | (p << 1) | (s == 2 ? 32'h8 : 32'h0);
        wr(cfg);
        {r, z} = ocExp(p[1:0], s == 2);
        hit(s == 0 ? 9'h004 : 9'h002, {!r, !z}, {!r, !z}, 3);
        tick(RT + 2);
        check("retry", {alarmPinLow, gateOut.active}, (p == 1 || !r) ? 2'b11 : {1'b0, !z});
        clr();
      end
    end
    for (int u = 3; u < 7; u++) begin
      cfg = $urandom & 32'h20;
      wr(cfg);
      r = u > 4 || !cfg[5];
      hit(9'h1 << u, {!r, !r}, 2'b11, 45);
    end
    for (int w = 0; w < 2; w++) begin
      cfg = w;
      wr(cfg);
      hit(9'h100, {w == 0, 1'b1}, 2'b11, 3);
    end
    cfg = 32'h0;
    wr(cfg);
    hit(9'h001, 2'b00, 2'b00, 3);
    clr();
    cfg = 32'h10;
    wr(cfg);
    hit(9'h001, 2'b11, 2'b11, 3);
    cfg = 32'h3E;
    wr(cfg);
    hit(9'h080, 2'b00, 2'b11, 45);
    apb(1'b0, frp_pkg::ADDR_STATUS, '0, rd, er);
    check("trip", rd[2:0], 3'b101);
    ctl.pulse(100);
    tick(3);
    check("pulse", {anyAlarmFlag, regulatorsOn}, 2'b01);
    apb(1'b0, frp_pkg::ADDR_CTRL, '0, rd, er);
    check("kept", rd, cfg);
    ctl.rest();
    tick(700);
    check("sleep", {regulatorsOn, gateOut}, 4'b0011);
    up();
    apb(1'b0, frp_pkg::ADDR_CTRL, '0, rd, er);
    check("ctrl default", rd, 32'h0);
    conclude();
  end
endmodule
bind frp_fault_power frp_fault_power_assertions #(.SLEEP_CYCLES(SLEEP_CYCLES)) chk (
  .sys_clk, .reset, .psel, .penable, .pready, .enable, .faultIn, .alarmPinLow,
  .anyAlarmFlag, .gateOut, .chargePumpOn, .regulatorsOn, .readyForInputs);
`default_nettype wire
